// *** arr_params.svh ***
// Constants for the fault reset and record block
`ifndef ARR_PARAMS_SVH
`define ARR_PARAMS_SVH
`define ARR_CLK_MHZ 125
`define ARR_CLEAR_HOLD_MS 10
`define ARR_CLEAR_HOLD_CYC (`ARR_CLEAR_HOLD_MS * 1000 * `ARR_CLK_MHZ)
`define ARR_LOG_DEPTH 10
`define ARR_CODE_W 8
`define ARR_CODE_NONE 8'h00
`endif

// *** arr_pkg.sv ***
// Types for the fault reset and record block
package arr_pkg;
    typedef enum logic [1:0] {
        ARR_HEALTHY,
        ARR_FAULTED,
        ARR_LOCKED
    } arr_state_t;
endpackage

// *** arr_alarm_core.sv ***
// Fault handling core: alarm output, brake, display, clear and fault log
`timescale 1ns/10ps
`default_nettype none
`include "arr_params.svh"

// ----------------------------------------------------------------
// Fault log slot
// ----------------------------------------------------------------
// Each slot wipes, takes its upstream neighbour's code (slot 0 takes the new fault code), or holds
module arr_log_slot #(
    parameter int CODE_W = `ARR_CODE_W
) (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic wipe_i,
    input wire logic shift_i,
    input wire logic [CODE_W-1:0] load_code_i,
    output logic [CODE_W-1:0] slot_code_o
);
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            slot_code_o <= CODE_W'(`ARR_CODE_NONE);
        end else if (wipe_i) begin
            slot_code_o <= CODE_W'(`ARR_CODE_NONE);
        end else if (shift_i) begin
            slot_code_o <= load_code_i;
        end
    end
endmodule // arr_log_slot

// ----------------------------------------------------------------
// Fault handling core
// ----------------------------------------------------------------
module arr_alarm_core #(
    parameter int CODE_W = `ARR_CODE_W,
    parameter int LOG_DEPTH = `ARR_LOG_DEPTH,
    parameter int CMD_W = 4,
    parameter int HOLD_CYC = `ARR_CLEAR_HOLD_CYC
) (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic fault_req_i,
    input wire logic [CODE_W-1:0] fault_code_i,
    input wire logic fault_power_only_i,
    input wire logic warn_req_i,
    input wire logic [CODE_W-1:0] warn_code_i,
    input wire logic fault_clear_input_i,
    input wire logic forward_run_input_i,
    input wire logic [CMD_W-1:0] run_cmd_i,
    input wire logic panel_clear_i,
    input wire logic panel_log_clear_i,
    input wire logic display_key_i,
    input wire logic [3:0] log_index_i,
    output logic fault_status_output_o,
    output logic motor_stop_o,
    output logic brake_hold_o,
    output logic warning_o,
    output logic [CODE_W-1:0] display_code_o,
    output logic clear_done_o,
    output logic [CODE_W-1:0] log_code_o,
    output logic [3:0] log_count_o
);
    // ----------------------------------------------------------------
    // Local signals
    // ----------------------------------------------------------------
    arr_pkg::arr_state_t state;
    arr_pkg::arr_state_t next_state;
    logic [CODE_W-1:0] code;
    logic [CODE_W-1:0] next_code;
    logic clear_in_d;
    logic [31:0] hold_cnt;
    logic [31:0] next_hold_cnt;
    logic hold_ok;
    logic cmd_active;
    logic clear_fall;
    logic input_clear;
    logic any_clear;
    logic new_fault;
    logic in_fault;
    logic faulted;
    logic next_clear_done;
    logic log_wipe;
    logic log_shift;
    logic [3:0] next_log_count;
    logic [CODE_W-1:0] next_log_code;
    logic [CODE_W-1:0] log_mem [LOG_DEPTH];
    logic [CODE_W-1:0] log_feed [LOG_DEPTH];

    // ----------------------------------------------------------------
    // Clear qualification
    // ----------------------------------------------------------------
    // Any operation command blocks the clear input outright
    assign cmd_active = forward_run_input_i | (|run_cmd_i);
    // Hold counter saturates; it clears while the input is low or a command is active
    assign hold_ok = (hold_cnt >= 32'(HOLD_CYC));
    // Acting on the falling edge lets the host see the fault before it goes
    assign clear_fall = clear_in_d & ~fault_clear_input_i;
    assign input_clear = clear_fall
                       & hold_ok
                       & ~cmd_active;
    assign any_clear = input_clear | panel_clear_i;
    assign in_fault = (state != arr_pkg::ARR_HEALTHY);
    assign new_fault = fault_req_i & ~in_fault;

    // ----------------------------------------------------------------
    // Clear hold counter and edge register
    // ----------------------------------------------------------------
    // Commands during the hold void it, so the host must drop them first
    always_comb begin
        next_hold_cnt = hold_cnt;
        if (!fault_clear_input_i || cmd_active) begin
            next_hold_cnt = 32'h00000000;
        end else if (!hold_ok) begin
            next_hold_cnt = hold_cnt + 32'h00000001;
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            clear_in_d <= 1'b0;
            hold_cnt <= 32'h00000000;
        end else begin
            clear_in_d <= fault_clear_input_i;
            hold_cnt <= next_hold_cnt;
        end
    end

    // ----------------------------------------------------------------
    // Fault state
    // ----------------------------------------------------------------
    always_comb begin
        next_state = state;
        next_code = code;
        unique case (state)
            arr_pkg::ARR_HEALTHY: begin
                if (fault_req_i) begin
                    next_code = fault_code_i;
                    if (fault_power_only_i) begin
                        next_state = arr_pkg::ARR_LOCKED;
                    end else begin
                        next_state = arr_pkg::ARR_FAULTED;
                    end
                end
            end
            arr_pkg::ARR_FAULTED: begin
                if (any_clear) begin
                    next_state = arr_pkg::ARR_HEALTHY;
                    next_code = CODE_W'(`ARR_CODE_NONE);
                end
            end
            arr_pkg::ARR_LOCKED: begin
                // No clear request leaves this state; only reset does
                next_state = arr_pkg::ARR_LOCKED;
            end
            default: begin
                // The spare encoding falls back to a safe healthy restart
                next_state = arr_pkg::ARR_HEALTHY;
            end
        endcase
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            state <= arr_pkg::ARR_HEALTHY;
            code <= CODE_W'(`ARR_CODE_NONE);
        end else begin
            state <= next_state;
            code <= next_code;
        end
    end

    // ----------------------------------------------------------------
    // Outputs toward motor, brake and panel
    // ----------------------------------------------------------------
    // Combinational from the request so drop, stop and brake share the fault cycle
    assign faulted = in_fault | fault_req_i;
    assign fault_status_output_o = ~faulted;
    assign motor_stop_o = faulted;
    assign brake_hold_o = faulted;
    // Warning shows only while no fault is up, so it leads the fault
    assign warning_o = warn_req_i & ~faulted;

    always_comb begin
        if (new_fault) begin
            display_code_o = fault_code_i;
        end else if (in_fault) begin
            display_code_o = code;
        end else if (warn_req_i) begin
            display_code_o = warn_code_i;
        end else begin
            display_code_o = CODE_W'(`ARR_CODE_NONE);
        end
    end

    // ----------------------------------------------------------------
    // Clear-done indication
    // ----------------------------------------------------------------
    // A set in the same cycle as a key press wins, so no input clear goes unseen
    always_comb begin
        next_clear_done = clear_done_o;
        if (state == arr_pkg::ARR_FAULTED && input_clear) begin
            next_clear_done = 1'b1;
        end else if (display_key_i) begin
            next_clear_done = 1'b0;
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            clear_done_o <= 1'b0;
        end else begin
            clear_done_o <= next_clear_done;
        end
    end

    // ----------------------------------------------------------------
    // Fault log, newest at index 0
    // ----------------------------------------------------------------
    // Held in flip-flops; the reset stands in for the non-volatile store here
    // A wipe in the same cycle as a new fault wins, so the log ends empty
    assign log_wipe = panel_log_clear_i;
    assign log_shift = new_fault & ~panel_log_clear_i;

    genvar g;
    generate
        for (g = 0; g < LOG_DEPTH; g++) begin : g_slot
            if (g == 0) begin : g_head
                assign log_feed[g] = fault_code_i;
            end else begin : g_tail
                // The last slot's code falls off the end when a new one enters
                assign log_feed[g] = log_mem[g-1];
            end
            arr_log_slot #(.CODE_W(CODE_W)) slot_u (
                .clock_i(clock_i),
                .rst_n_i(rst_n_i),
                .wipe_i(log_wipe),
                .shift_i(log_shift),
                .load_code_i(log_feed[g]),
                .slot_code_o(log_mem[g])
            );
        end
    endgenerate

    always_comb begin
        next_log_count = log_count_o;
        if (log_wipe) begin
            next_log_count = 4'h0;
        end else if (log_shift && (log_count_o < 4'(LOG_DEPTH))) begin
            next_log_count = log_count_o + 4'h1;
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            log_count_o <= 4'h0;
        end else begin
            log_count_o <= next_log_count;
        end
    end

    // ----------------------------------------------------------------
    // Log readout
    // ----------------------------------------------------------------
    // Indices past the filled part read as no code rather than stale data
    always_comb begin
        next_log_code = CODE_W'(`ARR_CODE_NONE);
        if (log_index_i < log_count_o) begin
            next_log_code = log_mem[log_index_i];
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            log_code_o <= CODE_W'(`ARR_CODE_NONE);
        end else begin
            log_code_o <= next_log_code;
        end
    end
endmodule // arr_alarm_core
`default_nettype wire

// *** arr_alarm_core_asserts.sv ***
// Checker for the alarm core ports
`timescale 1ns/10ps
`default_nettype none
module arr_alarm_core_asserts #(parameter int CODE_W = 8, parameter int LOG_DEPTH = 10) (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic fault_req_i,
    input wire logic [CODE_W-1:0] fault_code_i,
    input wire logic fault_clear_input_i,
    input wire logic forward_run_input_i,
    input wire logic [3:0] run_cmd_i,
    input wire logic display_key_i,
    input wire logic panel_log_clear_i,
    input wire logic fault_status_output_o,
    input wire logic motor_stop_o,
    input wire logic brake_hold_o,
    input wire logic [CODE_W-1:0] display_code_o,
    input wire logic clear_done_o,
    input wire logic [3:0] log_count_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    a_fault_drops_ok: assert property (fault_req_i |-> !fault_status_output_o && motor_stop_o)
        else $error("status high in fault");
    a_brake_on_fault: assert property (fault_req_i |-> brake_hold_o)
        else $error("brake off in fault");
    a_code_shown: assert property ($fell(fault_status_output_o) |-> display_code_o == fault_code_i)
        else $error("code not shown");
    a_clear_on_fall: assert property ($rose(clear_done_o) |->
        $past(fault_clear_input_i, 2) && !$past(fault_clear_input_i))
        else $error("clear off falling edge");
    a_cmd_blocks_clear: assert property ($rose(clear_done_o) |->
        $past(run_cmd_i) == 4'h0 && !$past(forward_run_input_i))
        else $error("clear under command");
    a_done_holds: assert property (clear_done_o && !display_key_i |=> clear_done_o)
        else $error("clear done lost");
    a_log_wipe: assert property (panel_log_clear_i |=> log_count_o == 4'h0)
        else $error("log not wiped");
    a_log_bound: assert property (log_count_o <= LOG_DEPTH)
        else $error("log overfull");
    cover property ($rose(clear_done_o));
    cover property ($fell(fault_status_output_o));
    cover property (log_count_o == LOG_DEPTH);
endmodule // arr_alarm_core_asserts
`default_nettype wire

// *** arr_host_model.sv ***
// Host model driving the clear and run inputs
`timescale 1ns/10ps
`default_nettype none
module arr_host_model #(parameter int HOLD = 8) (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic go_i,
    input wire logic short_i,
    input wire logic run_i,
    output logic fault_clear_input_o,
    output logic forward_run_input_o,
    output logic busy_o
);
    int cnt;
    // A short hold exists only to be refused
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) cnt <= 0;
        else if (go_i) cnt <= short_i ? HOLD / 2 : HOLD + 1;
        else if (cnt != 0) cnt <= cnt - 1;
    end
    assign fault_clear_input_o = cnt != 0;
    assign forward_run_input_o = run_i;
    assign busy_o = cnt != 0;
endmodule // arr_host_model
`default_nettype wire

// *** test_arr_alarm_core.sv ***
// Testbench for the alarm core
`timescale 1ns/10ps
`default_nettype none
module test_arr_alarm_core;
    logic clock_i = 0, rst_n_i = 0, freq = 0, pwr = 0, warn = 0, pclr = 0, lclr = 0, key = 0;
    logic go = 0, shrt = 0, run = 0, clr, forward_run_input, busy, ok, stp, brk, wrn, done;
    logic [7:0] code = 8'h5A, disp, lcode;
    logic [3:0] idx = 4'h0, cnt;
    int bad_count = 0, comparisons = 0;
    always #4 clock_i = ~clock_i;
    arr_alarm_core #(.HOLD_CYC(8)) dut_u (.clock_i, .rst_n_i, .fault_req_i(freq),
        .fault_code_i(code), .fault_power_only_i(pwr), .warn_req_i(warn), .warn_code_i(code),
        .fault_clear_input_i(clr), .forward_run_input_i(forward_run_input), .run_cmd_i({4{run}}),
        .panel_clear_i(pclr), .panel_log_clear_i(lclr), .display_key_i(key),
        .log_index_i(idx), .fault_status_output_o(ok), .motor_stop_o(stp),
        .brake_hold_o(brk), .warning_o(wrn), .display_code_o(disp), .clear_done_o(done),
        .log_code_o(lcode), .log_count_o(cnt));
    arr_host_model #(.HOLD(8)) host_u (.clock_i, .rst_n_i, .go_i(go), .short_i(shrt), .run_i(run),
        .fault_clear_input_o(clr), .forward_run_input_o(forward_run_input), .busy_o(busy));
    task automatic give_verdict();
        $display("checks %0d errors %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(string n, logic [7:0] e, logic [7:0] g);
        comparisons++;
        if (g !== e) begin
            bad_count++;
            $display("ERROR %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic tk(int n);
        repeat (n) @(posedge clock_i);
        #1;
    endtask
    task automatic fault(logic [7:0] c, logic p);
        code = c;
        pwr = p;
        freq = 1;
        #1;
        chk("ok", 8'h00, ok);
        chk("brake", 8'h01, brk);
        chk("stop", 8'h01, stp);
        chk("disp", c, disp);
        tk(1);
        freq = 0;
    endtask
    task automatic clear(logic s, logic r, logic e);
        run = r;
        shrt = s;
        go = 1;
        tk(1);
        go = 0;
        for (int i = 0; i < 20 && busy; i++) tk(1);
        if (busy) begin
            bad_count++;
            give_verdict();
        end
        tk(1);
        run = 0;
        chk("ok", e, ok);
        $display("test clear ends");
    endtask
    task automatic t_warn();
        warn = 1;
        #1;
        chk("warn", 8'h01, wrn);
        chk("wdisp", 8'h5A, disp);
        tk(1);
        warn = 0;
        $display("test warn ends");
    endtask
    task automatic t_log();
        for (int i = 1; i <= 12; i++) begin
            fault(i[7:0], 0);
            pclr = 1;
            tk(1);
            pclr = 0;
            chk("ok", 8'h01, ok);
        end
        chk("cnt", 8'h0A, cnt);
        idx = 4'h9;
        tk(1);
        chk("old", 8'h03, lcode);
        idx = 4'h0;
        tk(1);
        chk("new", 8'h0C, lcode);
        lclr = 1;
        tk(1);
        lclr = 0;
        chk("cnt", 8'h00, cnt);
        $display("test log ends");
    endtask
    initial begin
        tk(2);
        rst_n_i = 1;
        t_warn();
        fault(8'h3C, 0);
        clear(0, 1, 0);
        clear(1, 0, 0);
        clear(0, 0, 1);
        chk("done", 8'h01, done);
        key = 1;
        tk(1);
        key = 0;
        chk("done", 8'h00, done);
        fault(8'h77, 1);
        clear(0, 0, 0);
        rst_n_i = 0;
        tk(2);
        rst_n_i = 1;
        chk("ok", 8'h01, ok);
        t_log();
        give_verdict();
    end
endmodule // test_arr_alarm_core
bind arr_alarm_core arr_alarm_core_asserts #(.CODE_W(CODE_W), .LOG_DEPTH(LOG_DEPTH)) chk_u (.*);
`default_nettype wire
